// *** rtl/vfd_pkg.sv ***
// Package for the video frame DMA address block
package vfd_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CUR_A = 12'h1D0;
	localparam logic [11:0] OFS_END = 12'h1D4;
	localparam logic [11:0] OFS_START = 12'h1D8;
	localparam logic [11:0] OFS_INIT_A = 12'h1DC;
	localparam logic [11:0] OFS_CTRL = 12'h1E0;
	localparam logic [11:0] OFS_CUR_B = 12'h1C8;
	localparam logic [11:0] OFS_INIT_B = 12'h1E8;
	localparam int PTR_HI = 28;
	localparam int PTR_LO = 4;
	localparam int END_HI = 23;
	localparam int INIT_LAST_BIT = 30;
	localparam int INIT_EQ_BIT = 29;
	localparam int CTRL_DUAL_BIT = 7;
	localparam int CTRL_DRAM_BIT = 6;
	localparam int CTRL_EN_BIT = 5;
	localparam logic [4:0] CTRL_XFER_CODE = 5'h10;
	localparam logic [24:0] PTR_RESET = 25'h0000000;
	localparam logic CTRL_RESET = 1'h0;

	typedef logic [24:0] vfd_qaddr_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} vfd_bus_req_t;

	typedef struct packed {
		logic valid;
		vfd_qaddr_t addr;
		logic lower;
	} vfd_fetch_t;
endpackage

// *** rtl/vfd_ptr_step.sv ***
// Next-fetch pointer with wrap from end to start
`timescale 1ns/1ns
module vfd_ptr_step (
	// Pointer in
	input wire vfd_pkg::vfd_qaddr_t cur,
	input wire vfd_pkg::vfd_qaddr_t endPtr,
	input wire vfd_pkg::vfd_qaddr_t startPtr,
	// Pointer out
	output vfd_pkg::vfd_qaddr_t nextPtr,
	output logic atEnd
);
	// End register only covers address bits 23:4
	assign atEnd = (cur[19:0] == endPtr[19:0]) && (cur[24:20] == 5'h00);
	assign nextPtr = atEnd ? startPtr : vfd_pkg::vfd_qaddr_t'(cur + 25'h0000001);
endmodule // vfd_ptr_step

// *** rtl/vfd_dma_addr.sv ***
// Video frame DMA address generator with register port
//
// Overview of operation
// - Current-A pointer holds bits 28:4 as live fetch address, low bits zero.
// - End register holds bits 23:4, address of last frame qword.
// - Start register holds bits 28:4, first qword of frame buffer.
// - All address registers drop written bits 3:0, read them as zero.
// - Initial-A bit 30 is last flag, stored as written whatever the end value, reads back.
// - Initial-A read gives comparator equality in bit 29, zero in bit 31.
// - Each frame starts at initial register, giving hardware scroll.
// - Single panel and CRT use only the A pointer set.
// - Control bit 7 selects dual-panel mode, reads back.
// - Control bit 5 enables video and cursor DMA, reads back.
// - During flyback each initial value is copied into its current pointer.
// - Dual-panel mode uses second current pointer for the lower panel.
`timescale 1ns/1ns
module vfd_dma_addr (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register port
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Display pipeline
	input wire logic flyback,
	input wire logic fetchDone,
	input wire logic fetchLower,
	// Memory controller side
	output vfd_pkg::vfd_fetch_t fetchReq,
	output logic dmaEnable,
	output logic dualPanel
);
	typedef enum logic [1:0] {ST_IDLE, ST_FLYBACK, ST_ACTIVE} vfd_phase_t;

	typedef struct packed {
		vfd_pkg::vfd_qaddr_t curA;
		vfd_pkg::vfd_qaddr_t curB;
		logic [19:0] endPtr;
		vfd_pkg::vfd_qaddr_t startPtr;
		vfd_pkg::vfd_qaddr_t initA;
		logic lastA;
		vfd_pkg::vfd_qaddr_t initB;
		logic lastB;
		logic dual;
		logic en;
		logic [31:0] rdata;
		vfd_pkg::vfd_fetch_t fetch;
		vfd_phase_t phase;
	} vfd_state_t;

	vfd_state_t st_r;
	vfd_state_t st_nxt;
	vfd_pkg::vfd_bus_req_t req;
	vfd_pkg::vfd_qaddr_t endFull;
	vfd_pkg::vfd_qaddr_t nxtA;
	vfd_pkg::vfd_qaddr_t nxtB;
	logic endA;
	logic endB;
	logic eqA;
	logic eqB;

	function automatic vfd_pkg::vfd_qaddr_t qword(input logic [31:0] d);
		qword = d[vfd_pkg::PTR_HI:vfd_pkg::PTR_LO];
	endfunction

	function automatic logic [31:0] ptrWord(input vfd_pkg::vfd_qaddr_t p);
		ptrWord = {3'h0, p, 4'h0};
	endfunction

	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
	assign endFull = {5'h00, st_r.endPtr};
	assign eqA = (st_r.initA == endFull);
	assign eqB = (st_r.initB == endFull);

	////////////////////////////////////////////////////////////////////
	// Wrap logic for each panel pointer
	vfd_ptr_step uStepA (
		.cur(st_r.curA),
		.endPtr(endFull),
		.startPtr(st_r.startPtr),
		.nextPtr(nxtA),
		.atEnd(endA)
	);

	vfd_ptr_step uStepB (
		.cur(st_r.curB),
		.endPtr(endFull),
		.startPtr(st_r.startPtr),
		.nextPtr(nxtB),
		.atEnd(endB)
	);

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = 32'h00000000;
		if (req.wr) begin
			case (req.addr)
				vfd_pkg::OFS_CUR_A: st_nxt.curA = qword(req.wdata);
				vfd_pkg::OFS_CUR_B: st_nxt.curB = qword(req.wdata);
				vfd_pkg::OFS_END: st_nxt.endPtr = req.wdata[vfd_pkg::END_HI:vfd_pkg::PTR_LO];
				vfd_pkg::OFS_START: st_nxt.startPtr = qword(req.wdata);
				vfd_pkg::OFS_INIT_A: begin
					st_nxt.initA = qword(req.wdata);
					st_nxt.lastA = req.wdata[vfd_pkg::INIT_LAST_BIT];
				end
				vfd_pkg::OFS_INIT_B: begin
					st_nxt.initB = qword(req.wdata);
					st_nxt.lastB = req.wdata[vfd_pkg::INIT_LAST_BIT];
				end
				vfd_pkg::OFS_CTRL: begin
					st_nxt.dual = req.wdata[vfd_pkg::CTRL_DUAL_BIT];
					st_nxt.en = req.wdata[vfd_pkg::CTRL_EN_BIT];
				end
				default: ;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				vfd_pkg::OFS_CUR_A: st_nxt.rdata = ptrWord(st_r.curA);
				vfd_pkg::OFS_CUR_B: st_nxt.rdata = ptrWord(st_r.curB);
				vfd_pkg::OFS_END: st_nxt.rdata = {8'h00, st_r.endPtr, 4'h0};
				vfd_pkg::OFS_START: st_nxt.rdata = ptrWord(st_r.startPtr);
				// Bit 31 zero, bit 29 live comparator
				vfd_pkg::OFS_INIT_A: st_nxt.rdata = {1'b0, st_r.lastA, eqA, st_r.initA, 4'h0};
				vfd_pkg::OFS_INIT_B: st_nxt.rdata = {1'b0, st_r.lastB, eqB, st_r.initB, 4'h0};
				vfd_pkg::OFS_CTRL: st_nxt.rdata = {24'h000000, st_r.dual, 1'b1, st_r.en,
					vfd_pkg::CTRL_XFER_CODE};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
		st_nxt.fetch.valid = 1'b0;
		case (st_r.phase)
			ST_IDLE: begin
				if (st_r.en && flyback) begin
					st_nxt.phase = ST_FLYBACK;
				end
			end
			ST_FLYBACK: begin
				st_nxt.curA = st_r.initA;
				st_nxt.curB = st_r.initB;
				if (!flyback) begin
					st_nxt.phase = st_r.en ? ST_ACTIVE : ST_IDLE;
				end
			end
			ST_ACTIVE: begin
				if (!st_r.en) begin
					st_nxt.phase = ST_IDLE;
				end else if (flyback) begin
					st_nxt.phase = ST_FLYBACK;
				end else if (fetchDone) begin
					// Lower panel pointer only in dual mode
					if (st_r.dual && fetchLower) begin
						st_nxt.curB = nxtB;
					end else begin
						st_nxt.curA = nxtA;
					end
				end
			end
			default: st_nxt.phase = ST_IDLE;
		endcase
		if (st_r.phase == ST_ACTIVE && st_r.en) begin
			st_nxt.fetch.valid = 1'b1;
			st_nxt.fetch.lower = st_r.dual && fetchLower;
			st_nxt.fetch.addr = st_nxt.fetch.lower ? st_nxt.curB : st_nxt.curA;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= '0;
			st_r.dual <= vfd_pkg::CTRL_RESET;
			st_r.en <= vfd_pkg::CTRL_RESET;
			st_r.phase <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			regRdata <= 32'h00000000;
			fetchReq <= '0;
			dmaEnable <= 1'b0;
			dualPanel <= 1'b0;
		end else begin
			regRdata <= st_nxt.rdata;
			fetchReq <= st_nxt.fetch;
			dmaEnable <= st_nxt.en;
			dualPanel <= st_nxt.dual;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	// Register writes
	AST_CUR_WRITE: assert property (@(posedge mclk) disable iff (srst)
		regWr && regAddr == vfd_pkg::OFS_CUR_A && st_r.phase == ST_IDLE
		|=> st_r.curA == $past(regWdata[28:4]))
		else $error("current pointer write lost");
	AST_END_WRITE: assert property (@(posedge mclk) disable iff (srst)
		regWr && regAddr == vfd_pkg::OFS_END |=> st_r.endPtr == $past(regWdata[23:4]))
		else $error("end pointer write lost");
	AST_START_WRITE: assert property (@(posedge mclk) disable iff (srst)
		regWr && regAddr == vfd_pkg::OFS_START |=> st_r.startPtr == $past(regWdata[28:4]))
		else $error("start pointer write lost");
	AST_INIT_WRITE: assert property (@(posedge mclk) disable iff (srst)
		regWr && regAddr == vfd_pkg::OFS_INIT_A |=> st_r.initA == $past(regWdata[28:4])
		&& st_r.lastA == $past(regWdata[30]))
		else $error("initial register write lost");
	AST_CTRL_WRITE: assert property (@(posedge mclk) disable iff (srst)
		regWr && regAddr == vfd_pkg::OFS_CTRL |=> dualPanel == $past(regWdata[7])
		&& dmaEnable == $past(regWdata[5]))
		else $error("control write lost");

	// Register readback
	AST_CTRL_READ: assert property (@(posedge mclk) disable iff (srst)
		regRd && regAddr == vfd_pkg::OFS_CTRL |=> regRdata == {24'h000000,
		$past(st_r.dual), 1'b1, $past(st_r.en), vfd_pkg::CTRL_XFER_CODE})
		else $error("control readback wrong");
	AST_LOW_ZERO: assert property (@(posedge mclk) disable iff (srst)
		$past(regRd) |-> regRdata[3:0] == 4'h0)
		else $error("low address bits not zero");
	AST_CUR_READ: assert property (@(posedge mclk) disable iff (srst)
		regRd && regAddr == vfd_pkg::OFS_CUR_A |=> regRdata == {3'h0, $past(st_r.curA), 4'h0})
		else $error("current pointer readback wrong");
	AST_END_READ: assert property (@(posedge mclk) disable iff (srst)
		regRd && regAddr == vfd_pkg::OFS_END |=> regRdata[23:0] == {$past(st_r.endPtr), 4'h0})
		else $error("end pointer readback wrong");
	AST_START_READ: assert property (@(posedge mclk) disable iff (srst)
		regRd && regAddr == vfd_pkg::OFS_START
		|=> regRdata[28:0] == {$past(st_r.startPtr), 4'h0})
		else $error("start pointer readback wrong");
	AST_INIT_READ: assert property (@(posedge mclk) disable iff (srst)
		regRd && regAddr == vfd_pkg::OFS_INIT_A |=> !regRdata[31] &&
		regRdata[29] == $past(eqA) && regRdata[30] == $past(st_r.lastA))
		else $error("initial register readback wrong");
	AST_EQ_LIVE: assert property (@(posedge mclk) disable iff (srst)
		regRd && regAddr == vfd_pkg::OFS_INIT_A |=> regRdata[29] ==
		($past(st_r.initA) == {5'h00, $past(st_r.endPtr)}))
		else $error("equal bit does not follow comparison");

	// Phase control
	AST_FLYBACK_ENTER: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_IDLE && st_r.en && flyback |=> st_r.phase == ST_FLYBACK)
		else $error("flyback not entered");
	AST_FLYBACK_LOAD: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_FLYBACK && !(regWr && regAddr == vfd_pkg::OFS_INIT_A)
		|=> st_r.curA == $past(st_r.initA))
		else $error("flyback reload missing");
	AST_FLYBACK_LOAD_B: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_FLYBACK |=> st_r.curB == $past(st_r.initB))
		else $error("lower flyback reload missing");
	AST_EN_OFF: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_ACTIVE && !st_r.en |=> st_r.phase == ST_IDLE)
		else $error("fetching kept going after disable");
	AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_IDLE && !regWr |=> st_r.curA == $past(st_r.curA))
		else $error("pointer moved while idle");
	AST_NO_FETCH_IDLE: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase != ST_ACTIVE |=> !fetchReq.valid)
		else $error("fetch outside active phase");
	AST_DISABLED: assert property (@(posedge mclk) disable iff (srst)
		!dmaEnable |-> ##1 (!fetchReq.valid)[*2])
		else $error("fetch while disabled");
	AST_RESET: assert property (@(posedge mclk) disable iff (srst)
		$past(srst) |-> !dmaEnable && !dualPanel)
		else $error("control not cleared by reset");

	// Pointer stepping
	AST_STEP: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_ACTIVE && st_r.en && !flyback && fetchDone && !(st_r.dual && fetchLower)
		&& !endA && !regWr |=> st_r.curA == $past(st_r.curA) + 25'h1)
		else $error("pointer did not step");
	AST_WRAP: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_ACTIVE && st_r.en && !flyback && fetchDone && !(st_r.dual && fetchLower)
		&& endA && !regWr |=> st_r.curA == $past(st_r.startPtr))
		else $error("pointer did not wrap");
	AST_LOWER: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_ACTIVE && st_r.en && st_r.dual && !flyback && fetchDone && fetchLower
		&& !regWr |=> st_r.curA == $past(st_r.curA))
		else $error("upper pointer moved on lower fetch");
	AST_LOWER_IGNORED: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_ACTIVE && st_r.en && !st_r.dual && !flyback && fetchDone && fetchLower
		&& !endA && !regWr |=> st_r.curA == $past(st_r.curA) + 25'h1
		&& st_r.curB == $past(st_r.curB))
		else $error("lower select used in single panel mode");
	AST_STEP_B: assert property (@(posedge mclk) disable iff (srst)
		st_r.phase == ST_ACTIVE && st_r.en && st_r.dual && !flyback && fetchDone && fetchLower
		&& !endB && !regWr |=> st_r.curB == $past(st_r.curB) + 25'h1)
		else $error("lower pointer did not step");
	AST_FETCH_ADDR: assert property (@(posedge mclk) disable iff (srst)
		fetchReq.valid && !fetchReq.lower |-> fetchReq.addr == st_r.curA)
		else $error("upper fetch address wrong");
	AST_FETCH_LOWER: assert property (@(posedge mclk) disable iff (srst)
		fetchReq.valid && fetchReq.lower |-> fetchReq.addr == st_r.curB && $past(st_r.dual))
		else $error("lower fetch address wrong");

	////////////////////////////////////////////////////////////////////
	// Coverage
	COV_WRAP: cover property (@(posedge mclk) st_r.phase == ST_ACTIVE && fetchDone && endA);
	COV_FLYBACK: cover property (@(posedge mclk) st_r.phase == ST_FLYBACK ##1 st_r.phase == ST_ACTIVE);
	COV_DUAL: cover property (@(posedge mclk) fetchReq.valid && fetchReq.lower);
	COV_DISABLE: cover property (@(posedge mclk) st_r.phase == ST_ACTIVE ##1 st_r.phase == ST_IDLE);
	COV_EQUAL: cover property (@(posedge mclk) regRd && regAddr == vfd_pkg::OFS_INIT_A && eqA);
endmodule // vfd_dma_addr

// *** verification/vfd_mem_model.sv ***
// Memory controller and display pipeline model for the fetch link
`timescale 1ns/1ns
module vfd_mem_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Bench control
	input wire logic frameGap,
	input wire logic lowerSel,
	input wire logic [3:0] lat,
	// Fetch link
	input wire vfd_pkg::vfd_fetch_t fetchReq,
	output logic flyback,
	output logic fetchDone,
	output logic fetchLower
);
	logic [3:0] cnt_r;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		flyback <= frameGap & ~srst;
		fetchLower <= lowerSel;
		fetchDone <= 1'b0;
		// One qword served per request, fetchDone lat cycles after the request is seen
		if (srst || !fetchReq.valid || fetchDone) begin
			cnt_r <= 4'h0;
		end else if (cnt_r == lat) begin
			fetchDone <= 1'b1;
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule // vfd_mem_model

// *** verification/vfd_dma_addr_test.sv ***
// Self-checking bench for the video frame DMA address block
`timescale 1ns/1ns
module vfd_dma_addr_test;
	logic mclk, srst, regWr, regRd, frameGap, lowerSel;
	logic flyback, fetchDone, fetchLower, dmaEnable, dualPanel;
	logic [11:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic [3:0] lat;
	vfd_pkg::vfd_fetch_t fetchReq;
	int errCount, compares;
	logic [11:0] offs [4] = '{12'h1D0, 12'h1D4, 12'h1D8, 12'h1DC};
	logic [31:0] masks [4] = '{32'h1FFFFFF0, 32'h00FFFFF0, 32'h1FFFFFF0, 32'h5FFFFFF0};

	vfd_dma_addr i_dut (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flyback(flyback),
		.fetchDone(fetchDone), .fetchLower(fetchLower), .fetchReq(fetchReq),
		.dmaEnable(dmaEnable), .dualPanel(dualPanel));
	vfd_mem_model i_mem (.mclk(mclk), .srst(srst), .frameGap(frameGap), .lowerSel(lowerSel),
		.lat(lat), .fetchReq(fetchReq), .flyback(flyback), .fetchDone(fetchDone),
		.fetchLower(fetchLower));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			errCount++;
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk("regRdata", e, regRdata);
	endtask

	task automatic frame();
		@(posedge mclk);
		frameGap <= 1'b1;
		repeat (3) @(posedge mclk);
		frameGap <= 1'b0;
	endtask

	task automatic waitDone();
		for (int i = 0; i < 30; i++) begin
			@(posedge mclk);
			if (fetchDone === 1'b1) break;
		end
	endtask

	task automatic first(input logic [24:0] e);
		for (int i = 0; i < 30; i++) begin
			@(posedge mclk);
			#1;
			if (fetchReq.valid === 1'b1) break;
		end
		chk("fetchReq.addr", {7'h00, e}, {7'h00, fetchReq.addr});
	endtask

	task automatic fetch(input logic [24:0] e);
		logic [24:0] p;
		p = fetchReq.addr;
		waitDone();
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			#1;
			if (fetchReq.addr !== p) break;
		end
		chk("fetchReq.addr", {7'h00, e}, {7'h00, fetchReq.addr});
	endtask

	task automatic complete_run();
		if (errCount == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge mclk);
		errCount++;
		complete_run();
	end

	initial begin
		srst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 12'h000;
		regWdata = 32'h00000000;
		frameGap = 1'b0;
		lowerSel = 1'b0;
		lat = 4'h4;
		errCount = 0;
		compares = 0;
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		rd(12'h1E0, 32'h00000050);
		wr(12'h1E0, 32'h000000FF);
		rd(12'h1E0, 32'h000000F0);
		chk("dualPanel dmaEnable", 32'h3, {30'h0, dualPanel, dmaEnable});
		wr(12'h1E0, 32'h00000000);
		rd(12'h1E0, 32'h00000050);
		foreach (offs[i]) wr(offs[i], 32'hFFFFFFFF);
		foreach (offs[i]) rd(offs[i], masks[i]);
		rd(12'h1E4, 32'h00000000);
		wr(12'h1D4, 32'h0000012F);
		wr(12'h1DC, 32'h4000012F);
		rd(12'h1DC, 32'h60000120);
		wr(12'h1D8, 32'h00000100);
		wr(12'h1DC, 32'h00000110);
		rd(12'h1DC, 32'h00000110);
		wr(12'h1D0, 32'h00000000);
		wr(12'h1E0, 32'h00000020);
		lowerSel <= 1'b1;
		frame();
		first(25'h0000011);
		chk("fetchReq flags", 32'h2, {30'h0, fetchReq.valid, fetchReq.lower});
		fetch(25'h0000012);
		fetch(25'h0000010);
		lat <= 4'h9;
		fetch(25'h0000011);
		wr(12'h1E0, 32'h00000000);
		lat <= 4'h4;
		wr(12'h1E8, 32'h00000200);
		wr(12'h1E0, 32'h000000A0);
		frame();
		fetch(25'h0000021);
		chk("fetchReq flags", 32'h3, {30'h0, fetchReq.valid, fetchReq.lower});
		wr(12'h1E0, 32'h00000000);
		rd(12'h1C8, 32'h00000210);
		rd(12'h1D0, 32'h00000110);
		complete_run();
	end
endmodule // vfd_dma_addr_test
